// *** core/cwf_regs.vh ***
`ifndef CWF_REGS_VH
`define CWF_REGS_VH

// Byte addresses of the APB registers
`define CWF_ADDR_CAPACITY 12'h000
`define CWF_ADDR_FIRST_SET 12'h004
`define CWF_ADDR_FINAL_SET 12'h008
`define CWF_ADDR_FINAL_CLR 12'h00C
`define CWF_ADDR_FLAGS 12'h010
`define CWF_ADDR_INT_STAT 12'h014
`define CWF_ADDR_INT_MASK 12'h018

// Bit positions in the flag status word
`define CWF_FLAG_FINAL_BIT 1
`define CWF_FLAG_FIRST_BIT 2

// Bit positions in status and mask
`define CWF_IRQ_FIRST_SET 0
`define CWF_IRQ_FIRST_CLR 1
`define CWF_IRQ_FINAL_SET 2
`define CWF_IRQ_FINAL_CLR 3
`define CWF_IRQ_WIDTH 4

// Reset values of capacity and levels, signed mAh, and of the interrupt mask
`define CWF_RST_FIRST_SET 16'h0096
`define CWF_RST_FINAL_SET 16'h004B
`define CWF_RST_FINAL_CLR 16'h0064
`define CWF_RST_CAPACITY 16'h7FFF
`define CWF_RST_MASK 4'h0

// Level value that disables setting the final warning
`define CWF_DISABLED_LEVEL 16'hFFFF

`endif

// *** core/cwf_compare.v ***
`include "cwf_regs.vh"

module cwf_compare #(
	parameter WIDTH = 16
) (
	input wire clock_i,
	input wire rst_n_i,
	input wire update_i,
	input wire [WIDTH-1:0] charge_i,
	input wire [WIDTH-1:0] first_set_i,
	input wire [WIDTH-1:0] final_set_i,
	input wire [WIDTH-1:0] final_clr_i,
	output reg first_flag_o,
	output reg final_flag_o
);
	reg nxt_first;
	reg nxt_final;

	// Signed compare keeps negative capacity and the -1 level meaningful
	function lt;
		input [WIDTH-1:0] a;
		input [WIDTH-1:0] b;
		begin
			lt = $signed(a) < $signed(b);
		end
	endfunction

	always @* begin
		nxt_first = first_flag_o;
		nxt_final = final_flag_o;
		if (lt(charge_i, first_set_i)) begin
			nxt_first = 1'b1;
		end else if (lt(first_set_i, charge_i)) begin
			nxt_first = 1'b0;
		end
		if (final_set_i != `CWF_DISABLED_LEVEL && lt(charge_i, final_set_i)) begin
			nxt_final = 1'b1;
		end else if (final_flag_o && lt(final_clr_i, charge_i)) begin
			nxt_final = 1'b0;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			first_flag_o <= 1'b0;
			final_flag_o <= 1'b0;
		end else if (update_i) begin
			first_flag_o <= nxt_first;
			final_flag_o <= nxt_final;
		end
	end
endmodule // cwf_compare

// *** core/cwf_capacity_warning.v ***
// Function
// - Set first warning below its set level
// - Clear first warning above its set level
// - Low battery pin mirrors first warning
// - Set final warning below its set level
// - Final set level minus one disables setting
// - Clear final warning above its clear level
// - Both flags readable in flag word
`include "cwf_regs.vh"

module cwf_capacity_warning #(
	parameter WIDTH = 16
) (
	input wire clock_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output reg [31:0] prdata_o,
	output wire pslverr_o,
	input wire charge_valid_i,
	input wire [WIDTH-1:0] remaining_charge_value_i,
	output wire low_battery_pin_o,
	output wire irq_o
);
	reg [WIDTH-1:0] charge_ff;
	reg [WIDTH-1:0] first_set_ff;
	reg [WIDTH-1:0] final_set_ff;
	reg [WIDTH-1:0] final_clr_ff;
	reg [`CWF_IRQ_WIDTH-1:0] stat_ff;
	reg [`CWF_IRQ_WIDTH-1:0] mask_ff;
	reg update_ff;
	reg first_d_ff;
	reg final_d_ff;
	reg [31:0] nxt_rdata;
	reg mapped;
	reg [`CWF_IRQ_WIDTH-1:0] events;
	wire first_flag;
	wire final_flag;
	wire wr_acc;
	wire rd_acc;
	wire sw_cap_wr;
	wire [31:0] flag_word;

	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign rd_acc = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign sw_cap_wr = wr_acc && paddr_i == `CWF_ADDR_CAPACITY;

	function [31:0] sext;
		input [WIDTH-1:0] v;
		begin
			sext = {{(32-WIDTH){v[WIDTH-1]}}, v};
		end
	endfunction

	always @* begin
		case (paddr_i)
			`CWF_ADDR_CAPACITY, `CWF_ADDR_FIRST_SET, `CWF_ADDR_FINAL_SET, `CWF_ADDR_FINAL_CLR,
			`CWF_ADDR_FLAGS, `CWF_ADDR_INT_STAT, `CWF_ADDR_INT_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Capacity may come from the estimator port or from software
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			charge_ff <= `CWF_RST_CAPACITY;
			update_ff <= 1'b0;
		end else begin
			update_ff <= charge_valid_i | sw_cap_wr;
			if (charge_valid_i) begin
				charge_ff <= remaining_charge_value_i;
			end else if (sw_cap_wr) begin
				charge_ff <= pwdata_i[WIDTH-1:0];
			end
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			first_set_ff <= `CWF_RST_FIRST_SET;
			final_set_ff <= `CWF_RST_FINAL_SET;
			final_clr_ff <= `CWF_RST_FINAL_CLR;
			mask_ff <= `CWF_RST_MASK;
		end else if (wr_acc) begin
			case (paddr_i)
				`CWF_ADDR_FIRST_SET: first_set_ff <= pwdata_i[WIDTH-1:0];
				`CWF_ADDR_FINAL_SET: final_set_ff <= pwdata_i[WIDTH-1:0];
				`CWF_ADDR_FINAL_CLR: final_clr_ff <= pwdata_i[WIDTH-1:0];
				`CWF_ADDR_INT_MASK: mask_ff <= pwdata_i[`CWF_IRQ_WIDTH-1:0];
				default: mask_ff <= mask_ff;
			endcase
		end
	end

	cwf_compare #(
		.WIDTH(WIDTH)
	) u_compare (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.update_i(update_ff),
		.charge_i(charge_ff),
		.first_set_i(first_set_ff),
		.final_set_i(final_set_ff),
		.final_clr_i(final_clr_ff),
		.first_flag_o(first_flag),
		.final_flag_o(final_flag)
	);

	assign low_battery_pin_o = first_flag;

	always @* begin
		events = {`CWF_IRQ_WIDTH{1'b0}};
		events[`CWF_IRQ_FIRST_SET] = first_flag & ~first_d_ff;
		events[`CWF_IRQ_FIRST_CLR] = ~first_flag & first_d_ff;
		events[`CWF_IRQ_FINAL_SET] = final_flag & ~final_d_ff;
		events[`CWF_IRQ_FINAL_CLR] = ~final_flag & final_d_ff;
	end

	// A new event wins over a same-cycle write-one clear
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			first_d_ff <= 1'b0;
			final_d_ff <= 1'b0;
			stat_ff <= {`CWF_IRQ_WIDTH{1'b0}};
		end else begin
			first_d_ff <= first_flag;
			final_d_ff <= final_flag;
			if (wr_acc && paddr_i == `CWF_ADDR_INT_STAT) begin
				stat_ff <= (stat_ff & ~pwdata_i[`CWF_IRQ_WIDTH-1:0]) | events;
			end else begin
				stat_ff <= stat_ff | events;
			end
		end
	end

	assign irq_o = |(stat_ff & mask_ff);

	assign flag_word = ({31'h0, first_flag} << `CWF_FLAG_FIRST_BIT) |
		({31'h0, final_flag} << `CWF_FLAG_FINAL_BIT);

	always @* begin
		nxt_rdata = 32'h0;
		case (paddr_i)
			`CWF_ADDR_CAPACITY: nxt_rdata = sext(charge_ff);
			`CWF_ADDR_FIRST_SET: nxt_rdata = sext(first_set_ff);
			`CWF_ADDR_FINAL_SET: nxt_rdata = sext(final_set_ff);
			`CWF_ADDR_FINAL_CLR: nxt_rdata = sext(final_clr_ff);
			`CWF_ADDR_FLAGS: nxt_rdata = flag_word;
			`CWF_ADDR_INT_STAT: nxt_rdata = {28'h0, stat_ff};
			`CWF_ADDR_INT_MASK: nxt_rdata = {28'h0, mask_ff};
			default: nxt_rdata = 32'h0;
		endcase
	end

	// Read data registered in setup, valid through access phase
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0;
		end else if (rd_acc) begin
			prdata_o <= nxt_rdata;
		end
	end
endmodule // cwf_capacity_warning

// *** sim/cwf_monitor.sv ***
module cwf_monitor #(
	parameter WIDTH = 16
) (
	input wire clock_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire [31:0] prdata_o,
	input wire pslverr_o,
	input wire charge_valid_i,
	input wire [WIDTH-1:0] remaining_charge_value_i,
	input wire low_battery_pin_o,
	input wire irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire acc = psel_i && penable_i;
	wire acc_w = acc && pwrite_i;
	wire rd_flg = acc && !pwrite_i && paddr_i == 12'h010;
	ready_ok_a: assert property (acc |-> pready_o) else $error("no ready");
	map_err_a: assert property (acc |-> pslverr_o == (paddr_i > 12'h018)) else $error("bad pslverr");
	hole_zero_a: assert property (acc && !pwrite_i && paddr_i > 12'h018 |-> prdata_o == 32'h0) else $error("bad hole");
	flag_pin_a: assert property (rd_flg |-> prdata_o[2] == $past(low_battery_pin_o)) else $error("pin");
	flag_spare_a: assert property (rd_flg |-> prdata_o[31:3] == 29'h0 && !prdata_o[0]) else $error("spare");
	// Flags move one edge after the capacity is taken, by the port or by software
	pin_cause_a: assert property ($changed(low_battery_pin_o) |-> $past(charge_valid_i, 2) || !$past(rst_n_i) ||
		$past(acc_w && paddr_i == 12'h000, 2)) else $error("pin moved");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(acc_w) || !$past(rst_n_i)) else $error("irq fell");
	mask_off_a: assert property (acc_w && paddr_i == 12'h018 && pwdata_i[3:0] == 4'h0 |=> !irq_o) else $error("masked irq");
endmodule // cwf_monitor

bind cwf_capacity_warning cwf_monitor #(.WIDTH(WIDTH)) i_mon (.*);

// *** sim/cwf_host.sv ***
module cwf_host (
	input wire logic clock_i,
	input wire logic pready_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] q[$];
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	// Idle cycle after each transfer keeps psel from two writes in one step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clock_i);
		penable_o <= 1'b1;
		do @(posedge clock_i); while (pready_i !== 1'b1);
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
endmodule // cwf_host

// *** sim/tb_top.sv ***
`include "cwf_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, charge_valid_i;
	logic low_battery_pin_o, irq_o, f1, ff, p1, pf;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, seed;
	logic signed [15:0] cap, fs;
	logic [3:0] st;
	logic [31:0] rv [8] = '{32'h7FFF, 32'h96, 32'h4B, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};
	int fails, samples_checked, i;
	cwf_capacity_warning i_dut (.*, .remaining_charge_value_i(cap));
	cwf_host i_host (.clock_i, .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clock_i = 0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		give_verdict;
	end
	always @(posedge clock_i)
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
			chk(prdata_o, i_host.q.pop_front());
	initial begin
		seed = 32'hAD603424;
		{rst_n_i, charge_valid_i, cap, f1, ff, st} = '0;
		fs = 16'sh004B;
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		for (i = 0; i < 8; i++)
			i_host.rd(12'(i * 4), rv[i]);
		$display("reset test done");
		i_host.wr(`CWF_ADDR_INT_MASK, 32'h1);
		for (i = 0; i < 60; i++) begin
			if (i == 30) begin
				fs = 16'shFFFF;
				i_host.wr(`CWF_ADDR_FINAL_SET, 32'hFFFF);
			end
			p1 = f1;
			pf = ff;
			cap <= 16'($random(seed) % 250);
			charge_valid_i <= 1'b1;
			@(posedge clock_i);
			charge_valid_i <= 1'b0;
			repeat (3) @(posedge clock_i);
			if (cap < 16'sh0096)
				f1 = 1'b1;
			else if (cap > 16'sh0096)
				f1 = 1'b0;
			if (fs != -1 && cap < fs)
				ff = 1'b1;
			else if (ff && cap > 16'sh0064)
				ff = 1'b0;
			st = st | {pf & ~ff, ~pf & ff, p1 & ~f1, ~p1 & f1};
			chk(32'(low_battery_pin_o), 32'(f1));
			i_host.rd(`CWF_ADDR_FLAGS, {29'h0, f1, ff, 1'b0});
		end
		$display("flag test done");
		i_host.rd(`CWF_ADDR_INT_STAT, {28'h0, st});
		chk(32'(irq_o), 32'(st[0]));
		i_host.wr(`CWF_ADDR_INT_MASK, 32'h0);
		chk(32'(irq_o), 32'h0);
		i_host.wr(`CWF_ADDR_INT_STAT, 32'hF);
		i_host.rd(`CWF_ADDR_INT_STAT, 32'h0);
		$display("irq test done");
		give_verdict;
	end
endmodule // tb_top
